// File: src/ucr_map.svh
// register offsets, field positions and reset values of the uart channel register file
`ifndef UCR_MAP_SVH
`define UCR_MAP_SVH
`define UCR_OFF_DATA       3'h0
`define UCR_OFF_IEN        3'h1
`define UCR_OFF_IDENT      3'h2
`define UCR_OFF_LCTL       3'h3
`define UCR_OFF_MCTL       3'h4
`define UCR_OFF_LSTAT      3'h5
`define UCR_OFF_MSTAT      3'h6
`define UCR_OFF_SCRATCH    3'h7
`define UCR_ADDR_SHADOW    12'h080
`define UCR_ADDR_EVSTAT    12'h084
`define UCR_ADDR_EVMASK    12'h088
`define UCR_ADDR_MODE      12'h08C
`define UCR_ADDR_DIVISOR   12'h090
`define UCR_BIT_DIVISOR_LATCH_ACCESS       7
`define UCR_BIT_FIFO_EN    0
`define UCR_BIT_RX_CLR     1
`define UCR_BIT_TX_CLR     2
`define UCR_BIT_HOLDING_REGISTER_EMPTY       5
`define UCR_BIT_TRANSMITTER_EMPTY       6
`define UCR_BIT_RXFERR     7
`define UCR_IEN_MASK       8'h0F
`define UCR_MCTL_MASK      8'h1F
`define UCR_RST_IDENT      8'h01
`define UCR_RST_LSTAT      8'h60
`define UCR_RST_ZERO       8'h00
`define UCR_ID_NONE        3'h0
`define UCR_ID_LINE        3'h3
`define UCR_ID_RXDATA      3'h2
`define UCR_ID_TIMEOUT     3'h6
`define UCR_ID_HOLDING_REGISTER_EMPTY        3'h1
`define UCR_ID_MODEM       3'h0
`define UCR_EV_W           4
`endif

// File: src/ucr_pkg.sv
// types shared by the uart channel register file
package ucr_pkg;
   typedef logic [7:0] ucr_byte_t;
   typedef enum logic [1:0] {
      UCR_TX_IDLE  = 2'b00,
      UCR_TX_SHIFT = 2'b01,
      UCR_TX_LAST  = 2'b11
   } ucr_tx_state_t;
endpackage : ucr_pkg

// File: src/ucr_regs.sv
// register file of one uart channel, apb slave with character and modem interfaces
//
// Function
// [RULE1] line_control bit 7 maps offsets 0 and 1 onto divisor low/high bytes
// [RULE2] offset 0 read with access bit low returns oldest received character; code returns the latest, each rx_valid overwrites receive_buffer
// [RULE3] offset 0 write with access bit low loads transmit_holding
// [RULE4] offset 2 read returns pending flag, source id, zeros, fifo-enabled bits
// [RULE5] offset 2 write loads fifo_control: enable, clears, trigger level
// [RULE6] bit 0 of a character is shifted out and in first
// [RULE7] in legacy mode transmitter_empty set whenever shift register is empty
// [RULE8] scratch is plain storage, absent in legacy mode
// [RULE9] fifos disabled force ident bits 3,6,7 and line_status bit 7 to zero
// [RULE10] dma mode select bit is accepted but has no effect
// [RULE11] every fifo_control write is mirrored into a readable shadow copy
// [RULE12] aux_out_1 and aux_out_2 are stored and readable, drive no pin
// [RULE13] reset leaves interrupt_ident reading bit 0 high, others low
// [RULE14] reset leaves line_status zero except bits 5 and 6 high
// [RULE15] interrupt_enable has four enables in bits 0-3, upper bits zero
// [RULE16] line_control fields: word length, stop, parity, stick, break, access bit
// [RULE17] line_status fields: ready, overrun, parity, framing, break, empties, fifo error
`timescale 1ns/1ps
`include "ucr_map.svh"
module ucr_regs
   import ucr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_char,
   input  wire logic [3:0]  rx_errors,
   output logic             tx_load,
   output logic [7:0]       tx_char,
   input  wire logic        tx_shift_empty,
   output logic             rx_fifo_clear,
   output logic             tx_fifo_clear,
   output logic             rts_n,
   output logic             dtr_n,
   output logic             loopback,
   output logic [15:0]      baud_divisor,
   output logic [7:0]       line_cfg,
   output logic             tx_serial,
   input  wire logic        cts_n,
   input  wire logic        dsr_n,
   input  wire logic        ri_n,
   input  wire logic        dcd_n,
   output logic             irq
);
   ucr_byte_t     receive_buffer;
   ucr_byte_t     transmit_holding;
   ucr_byte_t     interrupt_enable;
   ucr_byte_t     line_control;
   ucr_byte_t     modem_control;
   ucr_byte_t     scratch;
   ucr_byte_t     fifo_control;
   ucr_byte_t     fifo_shadow;
   ucr_byte_t     modem_status;
   logic [4:0]    lstat_err;
   logic          data_ready;
   logic          holding_register_empty;
   logic          transmitter_empty;
   logic          legacy_mode;
   logic [3:0]    ev_status;
   logic [3:0]    ev_mask;
   logic [15:0]   divisor;
   logic [3:0]    modem_s1;
   logic [3:0]    modem_s2;
   logic [3:0]    modem_s3;
   ucr_tx_state_t tx_state;
   logic [7:0]    tx_shreg;
   logic [2:0]    tx_bits;
   logic          thr_full;

   logic       acc;
   logic       wr;
   logic       rd;
   logic       local_hit;
   logic [2:0] off;
   logic       divisor_latch_access;
   logic       fifo_on;
   ucr_byte_t  ident;
   ucr_byte_t  line_status;
   logic [3:0] ev_set;
   logic [3:0] modem_now;
   logic       next_tx_load;

   function automatic logic hit(input logic [2:0] o, input logic [2:0] want);
      hit = local_hit && (o == want);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   assign acc       = psel && penable;
   assign wr        = acc && pwrite;
   assign rd        = acc && !pwrite;
   assign local_hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
   assign off       = paddr[4:2];
   assign divisor_latch_access      = line_control[`UCR_BIT_DIVISOR_LATCH_ACCESS]; // RULE1
   assign fifo_on   = fifo_control[`UCR_BIT_FIFO_EN];

   // stable pin view: second and third stages must agree
   assign modem_now = (modem_s2 == modem_s3) ? ~modem_s3 : ~modem_s2;

   // source priority: line > rx data > holding empty > modem
   always_comb begin
      ident = `UCR_RST_IDENT; // RULE13
      if (interrupt_enable[2] && (lstat_err[4:1] != 4'h0)) begin
         ident[3:0] = {`UCR_ID_LINE, 1'b0};
      end else if (interrupt_enable[0] && data_ready) begin
         ident[3:0] = {`UCR_ID_RXDATA, 1'b0};
      end else if (interrupt_enable[1] && holding_register_empty) begin
         ident[3:0] = {`UCR_ID_HOLDING_REGISTER_EMPTY, 1'b0};
      end else if (interrupt_enable[3] && (modem_status[3:0] != 4'h0)) begin
         ident[3:0] = {`UCR_ID_MODEM, 1'b0};
      end
      ident[7:6] = {fifo_on, fifo_on}; // RULE4
      if (!fifo_on) begin
         ident[3] = 1'b0; // RULE9
      end
   end

   always_comb begin
      line_status = {lstat_err[0] & fifo_on, transmitter_empty, holding_register_empty,
                     lstat_err[4:1], data_ready}; // RULE17 RULE9
   end

   assign ev_set = {modem_status[3:0] != 4'h0, lstat_err[4:1] != 4'h0,
                    holding_register_empty, data_ready};

   ////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait state, unmapped offsets answer with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(local_hit ||
                    paddr == `UCR_ADDR_SHADOW || paddr == `UCR_ADDR_EVSTAT ||
                    paddr == `UCR_ADDR_EVMASK || paddr == `UCR_ADDR_MODE ||
                    paddr == `UCR_ADDR_DIVISOR);
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (1'b1)
               hit(off, `UCR_OFF_DATA):
                  prdata[7:0] <= divisor_latch_access ? divisor[7:0] : receive_buffer; // RULE1 RULE2
               hit(off, `UCR_OFF_IEN):
                  prdata[7:0] <= divisor_latch_access ? divisor[15:8] : interrupt_enable;
               hit(off, `UCR_OFF_IDENT):   prdata[7:0] <= ident; // RULE4
               hit(off, `UCR_OFF_LCTL):    prdata[7:0] <= line_control;
               hit(off, `UCR_OFF_MCTL):    prdata[7:0] <= modem_control; // RULE12
               hit(off, `UCR_OFF_LSTAT):   prdata[7:0] <= line_status;
               hit(off, `UCR_OFF_MSTAT):   prdata[7:0] <= modem_status;
               hit(off, `UCR_OFF_SCRATCH):
                  prdata[7:0] <= legacy_mode ? `UCR_RST_ZERO : scratch; // RULE8
               paddr == `UCR_ADDR_SHADOW:  prdata[7:0] <= fifo_shadow; // RULE11
               paddr == `UCR_ADDR_EVSTAT:  prdata[3:0] <= ev_status;
               paddr == `UCR_ADDR_EVMASK:  prdata[3:0] <= ev_mask;
               paddr == `UCR_ADDR_MODE:    prdata[0]   <= legacy_mode;
               paddr == `UCR_ADDR_DIVISOR: prdata[15:0] <= divisor;
               default:                    prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_enable <= `UCR_RST_ZERO;
         line_control     <= `UCR_RST_ZERO;
         modem_control    <= `UCR_RST_ZERO;
         scratch          <= `UCR_RST_ZERO;
         divisor          <= 16'h0000;
         legacy_mode      <= 1'b0;
         ev_mask          <= 4'h0;
      end else if (wr) begin
         if (hit(off, `UCR_OFF_DATA) && divisor_latch_access) begin
            divisor[7:0] <= pwdata[7:0]; // RULE1
         end
         if (hit(off, `UCR_OFF_IEN)) begin
            if (divisor_latch_access) begin
               divisor[15:8] <= pwdata[7:0]; // RULE1
            end else begin
               interrupt_enable <= pwdata[7:0] & `UCR_IEN_MASK; // RULE15
            end
         end
         if (hit(off, `UCR_OFF_LCTL)) begin
            line_control <= pwdata[7:0]; // RULE16
         end
         if (hit(off, `UCR_OFF_MCTL)) begin
            modem_control <= pwdata[7:0] & `UCR_MCTL_MASK; // RULE12
         end
         if (hit(off, `UCR_OFF_SCRATCH) && !legacy_mode) begin
            scratch <= pwdata[7:0]; // RULE8
         end
         if (paddr == `UCR_ADDR_EVMASK) begin
            ev_mask <= pwdata[3:0];
         end
         if (paddr == `UCR_ADDR_MODE) begin
            legacy_mode <= pwdata[0];
         end
         if (paddr == `UCR_ADDR_DIVISOR) begin
            divisor <= pwdata[15:0];
         end
      end
   end

   // fifo control and its shadow; clears are one-cycle pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_control  <= `UCR_RST_ZERO;
         fifo_shadow   <= `UCR_RST_ZERO;
         rx_fifo_clear <= 1'b0;
         tx_fifo_clear <= 1'b0;
      end else begin
         rx_fifo_clear <= 1'b0;
         tx_fifo_clear <= 1'b0;
         if (wr && hit(off, `UCR_OFF_IDENT)) begin
            // dma select bit 3 is stored only, nothing reads it
            fifo_control  <= {pwdata[7:6], 2'b00, pwdata[3], 2'b00, pwdata[0]}; // RULE5 RULE10
            fifo_shadow   <= pwdata[7:0]; // RULE11
            rx_fifo_clear <= pwdata[`UCR_BIT_RX_CLR] & pwdata[`UCR_BIT_FIFO_EN]; // RULE5
            tx_fifo_clear <= pwdata[`UCR_BIT_TX_CLR] & pwdata[`UCR_BIT_FIFO_EN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive side: a new character wins over a read that clears ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_buffer <= `UCR_RST_ZERO;
         data_ready     <= 1'b0;
         lstat_err      <= 5'h00; // RULE14
      end else begin
         if (rd && hit(off, `UCR_OFF_DATA) && !divisor_latch_access) begin
            data_ready <= 1'b0;
         end
         if (rd && hit(off, `UCR_OFF_LSTAT)) begin
            lstat_err <= 5'h00;
         end
         if (rx_valid) begin
            receive_buffer <= rx_char; // RULE2 RULE6
            data_ready     <= 1'b1;
            lstat_err[1]   <= data_ready && !fifo_on;
            lstat_err[4:2] <= rx_errors[2:0];
            lstat_err[0]   <= fifo_on && (rx_errors[2:0] != 3'h0);
            if (rx_errors[3]) begin
               lstat_err[1] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // holding register and lsb-first serialiser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_holding <= `UCR_RST_ZERO;
         thr_full         <= 1'b0;
         tx_state         <= UCR_TX_IDLE;
         tx_shreg         <= `UCR_RST_ZERO;
         tx_bits          <= 3'h0;
         tx_serial        <= 1'b1;
         tx_load          <= 1'b0;
         tx_char          <= `UCR_RST_ZERO;
      end else begin
         tx_load <= next_tx_load;
         if (wr && hit(off, `UCR_OFF_DATA) && !divisor_latch_access) begin
            transmit_holding <= pwdata[7:0]; // RULE3
            thr_full         <= 1'b1;
         end else if (next_tx_load) begin
            thr_full <= 1'b0;
         end
         case (tx_state)
            UCR_TX_IDLE: begin
               if (thr_full) begin
                  tx_shreg <= transmit_holding;
                  tx_char  <= transmit_holding;
                  tx_bits  <= 3'h7;
                  tx_state <= UCR_TX_SHIFT;
               end
            end
            UCR_TX_SHIFT: begin
               tx_serial <= tx_shreg[0]; // RULE6
               tx_shreg  <= {1'b0, tx_shreg[7:1]};
               tx_bits   <= tx_bits - 3'h1;
               if (tx_bits == 3'h0) begin
                  tx_state <= UCR_TX_LAST;
               end
            end
            UCR_TX_LAST: begin
               tx_serial <= 1'b1;
               tx_state  <= UCR_TX_IDLE;
            end
            default: tx_state <= UCR_TX_IDLE;
         endcase
      end
   end

   assign next_tx_load = (tx_state == UCR_TX_IDLE) && thr_full;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         holding_register_empty <= 1'b1; // RULE14
         transmitter_empty      <= 1'b1;
      end else begin
         holding_register_empty <= !thr_full || next_tx_load;
         if (legacy_mode) begin
            transmitter_empty <= tx_shift_empty; // RULE7
         end else begin
            transmitter_empty <= !thr_full && tx_shift_empty && (tx_state == UCR_TX_IDLE);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // modem pins: three-stage sync, deltas sticky until status read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_s1     <= 4'hF;
         modem_s2     <= 4'hF;
         modem_s3     <= 4'hF;
         modem_status <= `UCR_RST_ZERO;
      end else begin
         modem_s1 <= {dcd_n, ri_n, dsr_n, cts_n};
         modem_s2 <= modem_s1;
         modem_s3 <= modem_s2;
         if (rd && hit(off, `UCR_OFF_MSTAT)) begin
            modem_status[3:0] <= 4'h0;
         end
         if (modem_s2 == modem_s3) begin
            modem_status[7:4] <= modem_now;
            if (modem_now[0] != modem_status[4]) modem_status[0] <= 1'b1;
            if (modem_now[1] != modem_status[5]) modem_status[1] <= 1'b1;
            if (!modem_now[2] && modem_status[6]) modem_status[2] <= 1'b1;
            if (modem_now[3] != modem_status[7]) modem_status[3] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky events, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_status <= 4'h0;
         irq       <= 1'b0;
      end else begin
         if (wr && paddr == `UCR_ADDR_EVSTAT) begin
            ev_status <= (ev_status & ~pwdata[3:0]) | ev_set;
         end else begin
            ev_status <= ev_status | ev_set;
         end
         irq <= |(ev_status & ev_mask);
      end
   end

   // aux bits 2 and 3 intentionally stay internal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dtr_n        <= 1'b1;
         rts_n        <= 1'b1;
         loopback     <= 1'b0;
         baud_divisor <= 16'h0000;
         line_cfg     <= `UCR_RST_ZERO;
      end else begin
         dtr_n        <= !modem_control[0];
         rts_n        <= !modem_control[1];
         loopback     <= modem_control[4];
         baud_divisor <= divisor;
         line_cfg     <= line_control;
      end
   end

endmodule : ucr_regs

// File: verif/ucr_regs_asserts.sv
// concurrent checks on the apb side of the uart channel register file
`timescale 1ns/1ps
`include "ucr_map.svh"
module ucr_regs_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rx_fifo_clear,
   input wire logic        tx_fifo_clear,
   input wire logic [15:0] baud_divisor
);
   logic        wr_e;
   logic        rd_e;
   logic        mapped;
   logic        fen;
   logic        divisor_latch_access;
   logic [15:0] div_w;
   assign wr_e = psel && penable && pwrite && pready;
   assign rd_e = psel && penable && !pwrite && pready;
   assign mapped = (paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00)
      || (paddr >= `UCR_ADDR_SHADOW && paddr <= `UCR_ADDR_DIVISOR && paddr[1:0] == 2'b00);
   // shadow of the few control bits the checks depend on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fen   <= 1'b0;
         divisor_latch_access  <= 1'b0;
         div_w <= 16'h0000;
      end else if (wr_e) begin
         if (paddr == 12'h008) fen <= pwdata[0];
         if (paddr == 12'h00C) divisor_latch_access <= pwdata[7];
         if (paddr == `UCR_ADDR_DIVISOR) div_w <= pwdata[15:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////////////
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_unmapped: assert property (psel && !penable |=> pslverr == !$past(mapped))
      else $error("pslverr does not follow address decode");
   a_ien_upper: assert property (
      rd_e && paddr == 12'h004 && !divisor_latch_access |-> prdata[31:4] == 28'h0)
      else $error("interrupt enable upper bits not zero");
   a_ident_zeros: assert property (rd_e && paddr == 12'h008 |-> prdata[5:4] == 2'b00)
      else $error("ident bits 5:4 not zero");
   a_fifo_on_flag: assert property (
      rd_e && fen && paddr == 12'h008 |-> prdata[7:6] == 2'b11)
      else $error("fifo enabled flags missing");
   a_fifo_off_ident: assert property (
      rd_e && !fen && paddr == 12'h008 |-> prdata[7:6] == 2'b00 && !prdata[3])
      else $error("fifo only ident bits set with fifos off");
   a_fifo_off_lstat: assert property (rd_e && !fen && paddr == 12'h014 |-> !prdata[7])
      else $error("fifo error bit set with fifos off");
   a_divisor_copy: assert property (
      wr_e && paddr == `UCR_ADDR_DIVISOR |-> ##2 baud_divisor == div_w)
      else $error("baud divisor output not updated");
   a_rx_clear_cause: assert property (
      rx_fifo_clear == $past(wr_e && paddr == 12'h008 && pwdata[0] && pwdata[1]))
      else $error("rx fifo clear pulse wrong");
   a_tx_clear_cause: assert property (
      tx_fifo_clear == $past(wr_e && paddr == 12'h008 && pwdata[0] && pwdata[2]))
      else $error("tx fifo clear pulse wrong");
endmodule : ucr_regs_chk
////////////////////////////////////////////////////////////////////////////////
bind ucr_regs ucr_regs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .rx_fifo_clear, .tx_fifo_clear, .baud_divisor);

// File: verif/ucr_far.sv
// model of the serial line and modem side facing the register file
`timescale 1ns/1ps
module ucr_far (
   input  wire logic       pclk,
   input  wire logic       tx_serial,
   output logic            rx_valid,
   output logic [7:0]      rx_char,
   output logic [3:0]      rx_errors,
   output logic            tx_shift_empty,
   output logic            cts_n,
   output logic            dsr_n,
   output logic            ri_n,
   output logic            dcd_n
);
   initial begin
      rx_valid = 1'b0;
      rx_char = 8'h00;
      rx_errors = 4'h0;
      tx_shift_empty = 1'b1;
      {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
   end
   task send(input logic [7:0] c, input logic [3:0] e);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_char <= c;
      rx_errors <= e;
      @(posedge pclk);
      rx_valid <= 1'b0;
      // stale values are inverted so nothing relies on them
      rx_char <= ~c;
      rx_errors <= ~e;
   endtask : send
   task shift(input logic v);
      @(posedge pclk);
      tx_shift_empty <= v;
      @(posedge pclk);
   endtask : shift
   task modem(input logic [3:0] v);
      @(posedge pclk);
      {dcd_n, ri_n, dsr_n, cts_n} <= v;
   endtask : modem
   // first low sample is data bit 0, one bit per clock
   task grab(output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      for (n = 0; n < 200 && !ok; n++) begin
         @(posedge pclk);
         if (tx_serial === 1'b0) ok = 1'b1;
      end
      b[0] = tx_serial;
      for (n = 1; n < 8; n++) begin
         @(posedge pclk);
         b[n] = tx_serial;
      end
   endtask : grab
endmodule : ucr_far

// File: verif/ucr_regs_test.sv
// self-checking bench for the uart channel register file
`timescale 1ns/1ps
`include "ucr_map.svh"
module ucr_regs_test
   import ucr_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        rx_valid, tx_load, tx_shift_empty, rx_fifo_clear, tx_fifo_clear;
   logic        rts_n, dtr_n, loopback, tx_serial, cts_n, dsr_n, ri_n, dcd_n, ok;
   ucr_byte_t   rx_char, tx_char, line_cfg, b, ldch;
   logic [3:0]  rx_errors;
   logic [15:0] baud_divisor, d, s, c, t;
   logic [64:0] exp_q[$];
   logic [64:0] e_r;
   int          error_cnt, num_checks, rxc, txc, ldc;
   ucr_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rx_valid, .rx_char, .rx_errors, .tx_load, .tx_char, .tx_shift_empty,
      .rx_fifo_clear, .tx_fifo_clear, .rts_n, .dtr_n, .loopback, .baud_divisor, .line_cfg,
      .tx_serial, .cts_n, .dsr_n, .ri_n, .dcd_n, .irq);
   ucr_far far (.pclk, .tx_serial, .rx_valid, .rx_char, .rx_errors, .tx_shift_empty,
      .cts_n, .dsr_n, .ri_n, .dcd_n);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
////////////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   task miss(input string m);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask : miss
   task cmp_pin(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) miss("pin value differs");
   endtask : cmp_pin
   task cmp_rd(input logic [31:0] g, input logic er, input logic [64:0] e);
      num_checks++;
      if (((g ^ e[31:0]) & e[63:32]) !== 32'h0 || er !== e[64]) miss("read data differs");
   endtask : cmp_rd
   function automatic logic [11:0] ra(input logic [2:0] o);
      return {7'h00, o, 2'b00};
   endfunction : ra
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         miss("no pready");
         stop_test;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [15:0] wd);
      apb(1'b1, a, {16'h0, wd});
   endtask : wr
   task rd(input logic [11:0] a, input logic [15:0] e, input logic [15:0] m, input logic er);
      exp_q.push_back({er, 16'hFFFF, m, 16'h0, e});
      apb(1'b0, a, 32'h0);
   endtask : rd
////////////////////////////////////////////////////////////////////////////////
   // read results are matched in order against the notes left by rd
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) miss("unexpected read");
         else begin
            e_r = exp_q.pop_front();
            cmp_rd(prdata, pslverr, e_r);
         end
      end
      if (rx_fifo_clear === 1'b1) rxc++;
      if (tx_fifo_clear === 1'b1) txc++;
      if (tx_load === 1'b1) begin
         ldc++;
         ldch = tx_char;
      end
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
      error_cnt = 0; num_checks = 0; rxc = 0; txc = 0; ldc = 0;
      void'($urandom(32'hB783));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(ra(`UCR_OFF_IDENT), 16'h01, 16'hFF, 1'b0);
      rd(ra(`UCR_OFF_LSTAT), 16'h60, 16'hFF, 1'b0);
      rd(ra(`UCR_OFF_IEN), 16'h00, 16'hFF, 1'b0);
      $display("test reset done");
      d = 16'($urandom); s = 16'($urandom); c = 16'($urandom); t = 16'($urandom) & 16'h00FE;
      wr(ra(`UCR_OFF_LCTL), 16'h80);
      wr(ra(`UCR_OFF_DATA), d[7:0]);
      wr(ra(`UCR_OFF_IEN), d[15:8]);
      rd(ra(`UCR_OFF_IEN), d[15:8], 16'hFF, 1'b0);
      rd(`UCR_ADDR_DIVISOR, d, 16'hFFFF, 1'b0);
      cmp_pin(baud_divisor, d);
      wr(`UCR_ADDR_DIVISOR, s);
      rd(ra(`UCR_OFF_DATA), s[7:0], 16'hFF, 1'b0);
      wr(ra(`UCR_OFF_LCTL), 16'h3F);
      rd(ra(`UCR_OFF_LCTL), 16'h3F, 16'hFF, 1'b0);
      cmp_pin(line_cfg, 16'h3F);
      rd(ra(`UCR_OFF_IEN), 16'h00, 16'hFF, 1'b0);
      wr(ra(`UCR_OFF_IEN), 16'hFF);
      rd(ra(`UCR_OFF_IEN), 16'h0F, 16'hFF, 1'b0);
      wr(ra(`UCR_OFF_LCTL), 16'h03);
      $display("test divisor done");
      wr(ra(`UCR_OFF_SCRATCH), s[7:0]);
      rd(ra(`UCR_OFF_SCRATCH), s[7:0], 16'hFF, 1'b0);
      wr(`UCR_ADDR_MODE, 16'h01);
      wr(ra(`UCR_OFF_SCRATCH), ~s[7:0]);
      rd(ra(`UCR_OFF_SCRATCH), 16'h00, 16'hFF, 1'b0);
      far.shift(1'b0);
      rd(ra(`UCR_OFF_LSTAT), 16'h00, 16'h40, 1'b0);
      far.shift(1'b1);
      rd(ra(`UCR_OFF_LSTAT), 16'h40, 16'h40, 1'b0);
      wr(`UCR_ADDR_MODE, 16'h00);
      rd(ra(`UCR_OFF_SCRATCH), s[7:0], 16'hFF, 1'b0);
      $display("test scratch done");
      wr(ra(`UCR_OFF_IDENT), 16'h0F);
      rd(`UCR_ADDR_SHADOW, 16'h0F, 16'hFF, 1'b0);
      rd(ra(`UCR_OFF_IDENT), 16'hC0, 16'hF0, 1'b0);
      cmp_pin(16'(rxc + txc), 16'h2);
      wr(ra(`UCR_OFF_IDENT), 16'hCE);
      rd(`UCR_ADDR_SHADOW, 16'hCE, 16'hFF, 1'b0);
      rd(ra(`UCR_OFF_IDENT), 16'h00, 16'hC8, 1'b0);
      rd(ra(`UCR_OFF_LSTAT), 16'h00, 16'h80, 1'b0);
      cmp_pin(16'(rxc + txc), 16'h2);
      $display("test fifo control done");
      wr(`UCR_ADDR_EVMASK, 16'h01);
      far.send(c[7:0], 4'h0);
      repeat (3) @(negedge pclk);
      cmp_pin(16'(irq), 16'h1);
      rd(ra(`UCR_OFF_IDENT), 16'h04, 16'hFF, 1'b0);
      rd(ra(`UCR_OFF_LSTAT), 16'h01, 16'h01, 1'b0);
      rd(ra(`UCR_OFF_DATA), c[7:0], 16'hFF, 1'b0);
      wr(`UCR_ADDR_EVMASK, 16'h00);
      repeat (2) @(negedge pclk);
      cmp_pin(16'(irq), 16'h0);
      wr(`UCR_ADDR_EVMASK, 16'h01);
      wr(`UCR_ADDR_EVSTAT, 16'h01);
      repeat (2) @(negedge pclk);
      cmp_pin(16'(irq), 16'h0);
      far.send(c[15:8], 4'hF);
      rd(ra(`UCR_OFF_LSTAT), 16'h1F, 16'h1F, 1'b0);
      rd(ra(`UCR_OFF_LSTAT), 16'h00, 16'h1E, 1'b0);
      rd(ra(`UCR_OFF_DATA), c[15:8], 16'hFF, 1'b0);
      $display("test receive done");
      fork
         wr(ra(`UCR_OFF_DATA), t);
         far.grab(b, ok);
      join
      cmp_pin(16'(ldc), 16'h1);
      cmp_pin(16'(ldch), t);
      cmp_pin({7'h00, ok, b}, {8'h01, t[7:0]});
      wr(ra(`UCR_OFF_MCTL), 16'h1F);
      rd(ra(`UCR_OFF_MCTL), 16'h1F, 16'hFF, 1'b0);
      cmp_pin(16'({rts_n, dtr_n, loopback}), 16'h1);
      wr(ra(`UCR_OFF_MCTL), 16'h00);
      far.modem(4'hE);
      repeat (6) @(negedge pclk);
      rd(ra(`UCR_OFF_MSTAT), 16'h11, 16'hFF, 1'b0);
      rd(12'h0A0, 16'h00, 16'hFFFF, 1'b1);
      $display("test transmit and modem done");
      repeat (2) @(negedge pclk);
      if (exp_q.size() != 0) miss("reads left unanswered");
      stop_test;
   end
endmodule : ucr_regs_test
